// File: rtl/pmbus_mfr_command_decoder.sv
// decoder for the upper maker-specific command codes of a power controller
// assumes a bus engine that delivers whole transactions and the channel page
module pmbus_mfr_command_decoder import pmbus_mfr_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // transaction from the bus engine
   input  wire logic        txn_valid,
   input  wire txn_kind_e   txn_kind,
   input  wire logic [7:0]  txn_code,
   input  wire logic [15:0] txn_wdata,
   input  wire logic        page_sel,
   // answer to the bus engine
   output logic             rsp_valid,
   output logic             rsp_err,
   output logic      [15:0] rsp_data,
   output logic             blk_valid,
   output logic      [7:0]  blk_data,
   // measurements
   input  wire logic        meas_valid,
   input  wire logic [2:0]  meas_sel,
   input  wire logic [15:0] meas_data,
   // fault log capture
   input  wire logic        flog_valid,
   input  wire logic [15:0] flog_data,
   // store and restore requests from the lower command set
   input  wire logic        store_all_req,
   input  wire logic        restore_all_req,
   // pads
   input  wire logic [15:0] pads_in,
   // to the rest of the device
   output cfg_t             cfg_words,
   output logic             soft_reset_pulse
);

   dec_s        s;
   dec_s        next_s;
   logic [15:0] nv_rdata;
   logic        idle;

   // store and restore requests win over a transaction arriving the same cycle
   assign idle = (s.st == S_IDLE) && !store_all_req && !restore_all_req;

   nv_store u_nv (
      .clk   (clk),
      .srst  (srst),
      .we    (s.nv_we),
      .addr  (s.nv_addr),
      .wdata (s.nv_wdata),
      .rdata (nv_rdata)
   );

   always_comb begin
      logic        wipe;
      acc_e        acc;
      logic        ro;
      logic [3:0]  ci;
      logic [15:0] rd;
      logic        ok;
      logic [4:0]  last;
      wipe = 1'b0;
      acc  = A_NONE;
      ro   = 1'b0;
      ci   = 4'h0;
      rd   = 16'h0000;
      ok   = 1'b0;
      last = `CFG_LAST;
      next_s = s;
      next_s.rsp_valid = 1'b0;
      next_s.rsp_err   = 1'b0;
      next_s.blk_valid = 1'b0;
      next_s.nv_we     = 1'b0;
      next_s.pv        = 1'b0;
      next_s.rst_out   = 1'b0;

      // pads: three stages, a change counts once the last two agree
      next_s.p1 = pads_in;
      next_s.p2 = s.p1;
      next_s.p3 = s.p2;
      if (s.p2 == s.p3) begin
         next_s.pad = s.p3;
      end

      // working fault log is a ring; oldest entries are overwritten
      if (flog_valid) begin
         next_s.wlog[s.wptr] = flog_data;
         next_s.wptr = s.wptr + 3'h1;
      end

      unique case (s.st)
         S_IDLE: begin
            if (store_all_req) begin
               next_s.st  = S_SAVE;
               next_s.idx = 5'h00;
            end else if (restore_all_req) begin
               next_s.st  = S_LOAD;
               next_s.idx = 5'h00;
            end
         end
         S_SAVE, S_LSAVE, S_ERASE: begin
            next_s.nv_we = 1'b1;
            next_s.idx   = s.idx + 5'h01;
            if (s.st == S_SAVE) begin
               next_s.nv_addr  = s.idx;
               next_s.nv_wdata = s.cfg[s.idx[3:0]];
               last = `CFG_LAST;
            end else begin
               next_s.nv_addr  = `LOG_BASE | {2'h0, s.idx[2:0]};
               next_s.nv_wdata = (s.st == S_LSAVE) ? s.wlog[s.idx[2:0]] : `ERASED;
               last = `LOG_LAST;
            end
            if (s.idx == last) begin
               next_s.st = S_IDLE;
               if (s.st != S_SAVE) begin
                  next_s.logged = (s.st == S_LSAVE);
               end
            end
         end
         S_LOAD, S_CMP, S_BLK: begin
            last = (s.st == S_BLK) ? `LBYTE_LAST : `CFG_LAST;
            next_s.nv_addr = (s.st == S_BLK) ? (`LOG_BASE | {2'h0, s.idx[3:1]}) : s.idx;
            next_s.pv   = (s.idx <= last);
            next_s.pidx = s.idx;
            next_s.idx  = s.idx + 5'h01;
            if (s.pv) begin
               if (s.st == S_LOAD) begin
                  next_s.cfg[s.pidx[3:0]] = nv_rdata;
               end
               if (s.st == S_CMP && nv_rdata != s.cfg[s.pidx[3:0]]) begin
                  next_s.mismatch = 1'b1;
               end
               if (s.st == S_BLK) begin
                  next_s.blk_valid = 1'b1;
                  next_s.blk_data  = s.pidx[0] ? nv_rdata[15:8] : nv_rdata[7:0];
               end
               if (s.pidx == last) begin
                  next_s.st = S_IDLE;
               end
            end
         end
         default: begin
            next_s.st = S_IDLE;
         end
      endcase

      if (txn_valid) begin
         next_s.rsp_valid = 1'b1;
         next_s.rsp_data  = 16'h0000;
         case (txn_code)
            `CMD_OT_ACTION: begin acc = A_BYTE; ro = 1'b1; rd = `RST_OT_ACTION; end
            `CMD_IOUT_PK:   begin acc = A_WORD; ro = 1'b1; rd = s.peak[`PK_IOUT + {2'h0, page_sel}]; end
            `CMD_VOUT_PK:   begin acc = A_WORD; ro = 1'b1; rd = s.peak[`PK_VOUT + {2'h0, page_sel}]; end
            `CMD_TEXT_PK:   begin acc = A_WORD; ro = 1'b1; rd = s.peak[`PK_TEXT + {2'h0, page_sel}]; end
            `CMD_VIN_PK:    begin acc = A_WORD; ro = 1'b1; rd = s.peak[`PK_VIN]; end
            `CMD_TINT_PK:   begin acc = A_WORD; ro = 1'b1; rd = s.peak[`PK_TINT]; end
            `CMD_PADS:      begin acc = A_WORD; ro = 1'b1; rd = s.pad; end
            `CMD_STATUS: begin
               acc = A_BYTE;
               ro  = 1'b1;
               rd  = {13'h0000, s.logged, s.mismatch, s.st != S_IDLE};
            end
            `CMD_RETRY:     begin acc = A_WORD; ci = `CI_RETRY + {3'h0, page_sel}; end
            `CMD_RESTART:   begin acc = A_WORD; ci = `CI_RESTART + {3'h0, page_sel}; end
            `CMD_TEMPCO:    begin acc = A_WORD; ci = `CI_TEMPCO + {3'h0, page_sel}; end
            `CMD_SLOPE:     begin acc = A_WORD; ci = `CI_SLOPE + {3'h0, page_sel}; end
            `CMD_ADDEND:    begin acc = A_WORD; ci = `CI_ADDEND + {3'h0, page_sel}; end
            `CMD_RAIL:      begin acc = A_BYTE; ci = `CI_RAIL + {3'h0, page_sel}; end
            `CMD_ADDR:      begin acc = A_BYTE; ci = `CI_ADDR; end
            `CMD_PWM:       begin acc = A_BYTE; ci = `CI_PWM; end
            `CMD_PEAK_WIPE, `CMD_LOG_SAVE, `CMD_LOG_ERASE, `CMD_COMPARE, `CMD_SOFT_RST: begin
               acc = A_SEND;
            end
            `CMD_LOG_READ:  begin acc = A_BLOCK; end
            default:        begin acc = A_NONE; end
         endcase
         if (!ro && acc != A_SEND && acc != A_BLOCK) begin
            rd = s.cfg[ci];
         end
         // a busy sequencer refuses anything that would disturb working memory
         unique case (acc)
            A_SEND:  ok = (txn_kind == K_SEND) && idle;
            A_BYTE:  ok = (txn_kind == K_RBYTE) || (txn_kind == K_WBYTE && !ro && idle);
            A_WORD:  ok = (txn_kind == K_RWORD) || (txn_kind == K_WWORD && !ro && idle);
            A_BLOCK: ok = (txn_kind == K_BLOCK) && idle;
            default: ok = 1'b0;
         endcase
         next_s.rsp_err = !ok;
         if (ok) begin
            unique case (acc)
               A_BYTE, A_WORD: begin
                  if (txn_kind == K_RBYTE || txn_kind == K_RWORD) begin
                     next_s.rsp_data = (acc == A_BYTE) ? {8'h00, rd[7:0]} : rd;
                  end else if (ci == `CI_ADDR) begin
                     next_s.cfg[ci] = {9'h000, txn_wdata[6:0]};
                  end else begin
                     next_s.cfg[ci] = (acc == A_BYTE) ? {8'h00, txn_wdata[7:0]} : txn_wdata;
                  end
               end
               A_BLOCK: begin
                  next_s.rsp_data = `LOG_COUNT;
                  next_s.st  = S_BLK;
                  next_s.idx = 5'h00;
               end
               A_SEND: begin
                  unique case (txn_code)
                     `CMD_PEAK_WIPE: wipe = 1'b1;
                     `CMD_LOG_SAVE: begin
                        next_s.st  = S_LSAVE;
                        next_s.idx = 5'h00;
                     end
                     `CMD_LOG_ERASE: begin
                        next_s.st  = S_ERASE;
                        next_s.idx = 5'h00;
                     end
                     `CMD_COMPARE: begin
                        next_s.st       = S_CMP;
                        next_s.idx      = 5'h00;
                        next_s.mismatch = 1'b0;
                     end
                     default: begin
                        // reset of config, peaks, working log and compare flag (logged flag kept), then reload from the store
                        next_s.cfg      = cfg_default();
                        next_s.peak     = '0;
                        next_s.wlog     = '0;
                        next_s.wptr     = 3'h0;
                        next_s.mismatch = 1'b0;
                        next_s.st       = S_LOAD;
                        next_s.idx      = 5'h00;
                        next_s.rst_out  = 1'b1;
                     end
                  endcase
               end
               default: begin
               end
            endcase
         end
      end

      // raw compare: peaks assume monotonic codes within one quantity
      for (int i = 0; i < `NPEAK; i++) begin
         if (wipe) begin
            next_s.peak[i] = 16'h0000;
         end
      end
      // a sample in the wipe cycle survives the wipe
      if (meas_valid && (wipe || meas_data > next_s.peak[meas_sel])) begin
         next_s.peak[meas_sel] = meas_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s     <= '0;
         s.cfg <= cfg_default();
         s.st  <= S_LOAD;
      end else begin
         s <= next_s;
      end
   end

   assign rsp_valid        = s.rsp_valid;
   assign rsp_err          = s.rsp_err;
   assign rsp_data         = s.rsp_data;
   assign blk_valid        = s.blk_valid;
   assign blk_data         = s.blk_data;
   assign cfg_words        = s.cfg;
   assign soft_reset_pulse = s.rst_out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   peak_wipe_a: assert property (
      (idle && txn_valid && txn_kind == K_SEND && txn_code == `CMD_PEAK_WIPE && !meas_valid)
      |=> (s.peak == '0)) else $error("peaks not cleared");
   peak_take_a: assert property (
      (meas_valid && !txn_valid && meas_data > s.peak[meas_sel])
      |=> (s.peak[$past(meas_sel)] == $past(meas_data))) else $error("peak missed sample");
   peak_mono_a: assert property (
      !txn_valid |=> (s.peak[0] >= $past(s.peak[0]))) else $error("peak fell without wipe");
   addr_width_a: assert property (
      s.cfg[`CI_ADDR][15:7] == 9'h000) else $error("bus address wider than 7 bits");
   rail_page_a: assert property (
      (idle && txn_valid && txn_kind == K_WBYTE && txn_code == `CMD_RAIL)
      |=> (s.cfg[`CI_RAIL + {3'h0, $past(page_sel)}] == {8'h00, $past(txn_wdata[7:0])}))
      else $error("rail address not written to paged copy");
   log_save_a: assert property (
      (idle && txn_valid && txn_kind == K_SEND && txn_code == `CMD_LOG_SAVE)
      |=> (s.st == S_LSAVE)[*8] ##1 (s.st == S_IDLE && s.logged)) else $error("log save wrong");
   log_erase_a: assert property (
      (idle && txn_valid && txn_kind == K_SEND && txn_code == `CMD_LOG_ERASE)
      |=> (s.st == S_ERASE)[*8] ##1 (s.st == S_IDLE && !s.logged)) else $error("log erase wrong");
   block_read_a: assert property (
      (idle && txn_valid && txn_kind == K_BLOCK && txn_code == `CMD_LOG_READ)
      |=> (s.rsp_valid && s.rsp_data == `LOG_COUNT) ##2 s.blk_valid[*8])
      else $error("block read stream wrong");
   compare_a: assert property (
      (idle && txn_valid && txn_kind == K_SEND && txn_code == `CMD_COMPARE)
      |=> (s.st == S_CMP && !s.mismatch)) else $error("compare not started");
   soft_reset_a: assert property (
      (idle && txn_valid && txn_kind == K_SEND && txn_code == `CMD_SOFT_RST && !meas_valid)
      |=> (s.rst_out && s.st == S_LOAD && s.peak == '0)) else $error("soft reset wrong");
   load_end_a: assert property (
      $rose(s.st == S_LOAD) |-> ##15 (s.st == S_IDLE)) else $error("reload length wrong");
   retry_page_a: assert property (
      (idle && txn_valid && txn_kind == K_WWORD && txn_code == `CMD_RETRY)
      |=> (s.cfg[`CI_RETRY + {3'h0, $past(page_sel)}] == $past(txn_wdata)))
      else $error("retry wait not written");
   rsp_once_a: assert property (
      txn_valid |=> s.rsp_valid) else $error("transaction not answered");
   busy_refuse_a: assert property (
      (txn_valid && txn_kind == K_SEND && !idle)
      |=> s.rsp_err) else $error("send taken while busy");
   ro_write_a: assert property (
      (txn_valid && txn_kind == K_WWORD && txn_code == `CMD_IOUT_PK)
      |=> s.rsp_err) else $error("peak register took a write");
   addr_write_a: assert property (
      (idle && txn_valid && txn_kind == K_WBYTE && txn_code == `CMD_ADDR)
      |=> (s.cfg[`CI_ADDR] == {9'h000, $past(txn_wdata[6:0])}))
      else $error("bus address write wrong");
   restart_page_a: assert property (
      (idle && txn_valid && txn_kind == K_WWORD && txn_code == `CMD_RESTART)
      |=> (s.cfg[`CI_RESTART + {3'h0, $past(page_sel)}] == $past(txn_wdata)))
      else $error("restart hold not written");
   tempco_page_a: assert property (
      (idle && txn_valid && txn_kind == K_WWORD && txn_code == `CMD_TEMPCO)
      |=> (s.cfg[`CI_TEMPCO + {3'h0, $past(page_sel)}] == $past(txn_wdata)))
      else $error("tempco not written");
   slope_page_a: assert property (
      (idle && txn_valid && txn_kind == K_WWORD && txn_code == `CMD_SLOPE)
      |=> (s.cfg[`CI_SLOPE + {3'h0, $past(page_sel)}] == $past(txn_wdata)))
      else $error("slope not written");
   pwm_write_a: assert property (
      (idle && txn_valid && txn_kind == K_WBYTE && txn_code == `CMD_PWM)
      |=> (s.cfg[`CI_PWM] == {8'h00, $past(txn_wdata[7:0])}))
      else $error("pwm setup not written");
   status_bits_a: assert property (
      (txn_valid && txn_kind == K_RBYTE && txn_code == `CMD_STATUS)
      |=> (s.rsp_data[15:3] == 13'h0000 && s.rsp_data[0] == $past(s.st != S_IDLE)))
      else $error("status byte wrong");
   pad_sync_a: assert property (
      (s.p2 == s.p3) |=> (s.pad == $past(s.p3))) else $error("pad word not taken");
   store_len_a: assert property (
      (s.st == S_IDLE && store_all_req) |=> (s.st == S_SAVE) ##14 (s.st == S_IDLE))
      else $error("store length wrong");
   compare_end_a: assert property (
      $rose(s.st == S_CMP) |-> ##15 (s.st == S_IDLE)) else $error("compare length wrong");
   block_end_a: assert property (
      $rose(s.st == S_BLK) |-> ##17 (s.st == S_IDLE && s.blk_valid) ##1 !s.blk_valid)
      else $error("block stream length wrong");

endmodule // pmbus_mfr_command_decoder

// File: shared/pmbus_mfr_regs.svh
// constants for the maker-specific command decoder: codes, reset values, indices
// assumes it is included once through pmbus_mfr_pkg
`ifndef PMBUS_MFR_REGS_SVH
`define PMBUS_MFR_REGS_SVH

`define CMD_OT_ACTION   8'hd6
`define CMD_IOUT_PK     8'hd7
`define CMD_RETRY       8'hdb
`define CMD_RESTART     8'hdc
`define CMD_VOUT_PK     8'hdd
`define CMD_VIN_PK      8'hde
`define CMD_TEXT_PK     8'hdf
`define CMD_PEAK_WIPE   8'he3
`define CMD_PADS        8'he5
`define CMD_ADDR        8'he6
`define CMD_LOG_SAVE    8'hea
`define CMD_LOG_ERASE   8'hec
`define CMD_LOG_READ    8'hee
`define CMD_STATUS      8'hef
`define CMD_COMPARE     8'hf0
`define CMD_TINT_PK     8'hf4
`define CMD_PWM         8'hf5
`define CMD_TEMPCO      8'hf6
`define CMD_SLOPE       8'hf8
`define CMD_ADDEND      8'hf9
`define CMD_RAIL        8'hfa
`define CMD_SOFT_RST    8'hfd

`define RST_OT_ACTION   16'h00c0
`define RST_RETRY       16'hfabc
`define RST_RESTART     16'hfbe8
`define RST_ADDR        16'h004f
`define RST_PWM         16'h0014
`define RST_TEMPCO      16'h0f3c
`define RST_SLOPE       16'h4000
`define RST_ADDEND      16'h8000
`define RST_RAIL        16'h0080

// configuration word slots, paged ones take two (channel 0, channel 1)
`define CI_RETRY        4'h0
`define CI_RESTART      4'h2
`define CI_TEMPCO       4'h4
`define CI_SLOPE        4'h6
`define CI_ADDEND       4'h8
`define CI_RAIL         4'ha
`define CI_ADDR         4'hc
`define CI_PWM          4'hd
`define NCFG            14
`define CFG_LAST        5'h0d

// peak slots
`define PK_IOUT         3'h0
`define PK_VOUT         3'h2
`define PK_TEXT         3'h4
`define PK_VIN          3'h6
`define PK_TINT         3'h7
`define NPEAK           8

`define LOG_WORDS       8
`define LOG_LAST        5'h07
`define LBYTE_LAST      5'h0f
`define LOG_COUNT       16'h0010
`define LOG_BASE        5'h10
`define NV_DEPTH        32
`define ERASED          16'hffff

`endif

// File: shared/pmbus_mfr_pkg.sv
// types shared by the command decoder and its nonvolatile store
// assumes pmbus_mfr_regs.svh is on the include path
package pmbus_mfr_pkg;
`include "pmbus_mfr_regs.svh"

   typedef enum logic [2:0] {
      K_SEND  = 3'b000,
      K_WBYTE = 3'b001,
      K_WWORD = 3'b010,
      K_RBYTE = 3'b011,
      K_RWORD = 3'b100,
      K_BLOCK = 3'b101
   } txn_kind_e;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_SAVE  = 3'b001,
      S_LOAD  = 3'b010,
      S_CMP   = 3'b011,
      S_LSAVE = 3'b100,
      S_ERASE = 3'b101,
      S_BLK   = 3'b110
   } seq_e;

   typedef enum logic [2:0] {
      A_NONE  = 3'b000,
      A_SEND  = 3'b001,
      A_BYTE  = 3'b010,
      A_WORD  = 3'b011,
      A_BLOCK = 3'b100
   } acc_e;

   typedef logic [`NCFG-1:0][15:0] cfg_t;

   function automatic cfg_t cfg_default();
      cfg_t c;
      c = '0;
      for (int ch = 0; ch < 2; ch++) begin
         c[`CI_RETRY + 4'(ch)]   = `RST_RETRY;
         c[`CI_RESTART + 4'(ch)] = `RST_RESTART;
         c[`CI_TEMPCO + 4'(ch)]  = `RST_TEMPCO;
         c[`CI_SLOPE + 4'(ch)]   = `RST_SLOPE;
         c[`CI_ADDEND + 4'(ch)]  = `RST_ADDEND;
         c[`CI_RAIL + 4'(ch)]    = `RST_RAIL;
      end
      c[`CI_ADDR] = `RST_ADDR;
      c[`CI_PWM]  = `RST_PWM;
      return c;
   endfunction

   typedef struct packed {
      logic [`NV_DEPTH-1:0][15:0] mem;
   } nv_s;

   typedef struct packed {
      cfg_t                        cfg;
      logic [`NPEAK-1:0][15:0]     peak;
      logic [`LOG_WORDS-1:0][15:0] wlog;
      logic [2:0]                  wptr;
      seq_e                        st;
      logic [4:0]                  idx;
      logic                        pv;
      logic [4:0]                  pidx;
      logic                        mismatch;
      logic                        logged;
      logic [15:0]                 p1;
      logic [15:0]                 p2;
      logic [15:0]                 p3;
      logic [15:0]                 pad;
      logic                        rsp_valid;
      logic                        rsp_err;
      logic [15:0]                 rsp_data;
      logic                        blk_valid;
      logic [7:0]                  blk_data;
      logic                        nv_we;
      logic [4:0]                  nv_addr;
      logic [15:0]                 nv_wdata;
      logic                        rst_out;
   } dec_s;

endpackage

// File: rtl/nv_store.sv
// nonvolatile word store: configuration copy at low slots, fault log above
// assumes one write per cycle; read is combinational from the array
module nv_store import pmbus_mfr_pkg::*; (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // word access
   input  wire logic        we,
   input  wire logic [4:0]  addr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata
);

   nv_s s;
   nv_s next_s;

   // power-on loads the factory image; a real part keeps its cells instead
   function automatic nv_s image();
      nv_s m;
      cfg_t c;
      c = cfg_default();
      for (int i = 0; i < `NV_DEPTH; i++) begin
         m.mem[i] = (i < `NCFG) ? c[i] : `ERASED;
      end
      return m;
   endfunction

   always_comb begin
      next_s = s;
      if (we) begin
         next_s.mem[addr] = wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= image();
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.mem[addr];

endmodule // nv_store

// File: testbench/host_model.sv
// host model: presents one whole command transaction at a time
// assumes it shares the decoder clock and is driven through xfer
module host_model import pmbus_mfr_pkg::*; (
   // clock
   input  wire logic        clk,
   // request
   output logic             txn_valid,
   output txn_kind_e        txn_kind,
   output logic      [7:0]  txn_code,
   output logic      [15:0] txn_wdata,
   output logic             page_sel,
   // answer
   input  wire logic        rsp_valid,
   input  wire logic        rsp_err,
   input  wire logic [15:0] rsp_data,
   input  wire logic        blk_valid,
   input  wire logic [7:0]  blk_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] blk_q[$];
   initial begin
      txn_valid = 1'b0;
      txn_kind = K_SEND;
      txn_code = 8'h00;
      txn_wdata = 16'h0000;
      page_sel = 1'b0;
   end
   // released code and data lines flip so a stale value never looks valid
   task automatic xfer(input txn_kind_e k, input logic [7:0] c, input logic [15:0] d,
                       input logic p, output logic e, output logic [15:0] q);
      @(negedge clk);
      txn_valid = 1'b1;
      txn_kind = k;
      txn_code = c;
      txn_wdata = k == K_SEND ? ~txn_wdata : d;
      page_sel = p;
      @(negedge clk);
      e = rsp_valid ? rsp_err : 1'bx;
      q = rsp_data;
      txn_valid = 1'b0;
      txn_code = ~c;
      txn_wdata = ~txn_wdata;
   endtask
   always @(negedge clk)
      if (blk_valid)
         blk_q.push_back(blk_data);
endmodule // host_model

// File: testbench/test_pmbus_mfr_command_decoder.sv
// self-checking bench for the maker-specific command decoder
// assumes host_model issues transactions; other inputs move at the falling edge
module test_pmbus_mfr_command_decoder import pmbus_mfr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, srst = 1, txn_valid, page_sel, rsp_valid, rsp_err, blk_valid;
   logic        meas_valid = 0, flog_valid = 0, store_all_req = 0, restore_all_req = 0;
   logic        soft_reset_pulse, e;
   txn_kind_e   txn_kind;
   logic [7:0]  txn_code, blk_data;
   logic [15:0] txn_wdata, rsp_data, pads_in, q, v, lg[8], sh[2][8];
   logic [15:0] meas_data = 0, flog_data = 0, pk[8] = '{default: 16'h0000};
   logic [2:0]  meas_sel = 0;
   cfg_t        cfg_words;
   int          miscompares = 0, checks_done = 0, seed = 40;
   logic [7:0]  cd[8] = '{8'hdb, 8'hdc, 8'hf6, 8'hf8, 8'hf9, 8'hfa, 8'he6, 8'hf5};
   logic [15:0] df[8] = '{16'hfabc, 16'hfbe8, 16'h0f3c, 16'h4000, 16'h8000, 16'h0080,
                          16'h004f, 16'h0014};
   logic [7:0]  pc[5] = '{8'hd7, 8'hdd, 8'hdf, 8'hde, 8'hf4};

   pmbus_mfr_command_decoder uut (.clk, .srst, .txn_valid, .txn_kind, .txn_code, .txn_wdata,
      .page_sel, .rsp_valid, .rsp_err, .rsp_data, .blk_valid, .blk_data, .meas_valid,
      .meas_sel, .meas_data, .flog_valid, .flog_data, .store_all_req, .restore_all_req,
      .pads_in, .cfg_words, .soft_reset_pulse);
   host_model host (.clk, .txn_valid, .txn_kind, .txn_code, .txn_wdata, .page_sel,
      .rsp_valid, .rsp_err, .rsp_data, .blk_valid, .blk_data);

   always #25 clk = ~clk;

   task automatic tally_and_finish;
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, x, input string m);
      checks_done++;
      if (g !== x) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   // data is only meaningful on an accepted transaction
   task automatic op(input txn_kind_e k, input logic [7:0] c, input logic [15:0] d,
                     input logic p, ee, input logic [15:0] x);
      host.xfer(k, c, d, p, e, q);
      chk({15'h0, e}, {15'h0, ee}, "refusal");
      if (!ee)
         chk(q, x, "data");
   endtask
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1;
      @(negedge clk);
      s = 0;
   endtask
   function automatic int rnd(input int n);
      return {$random(seed)} % n;
   endfunction
   function automatic int slot(input int i, p);
      return i < 3 ? 2 * i + p : i + 3;
   endfunction
   function automatic txn_kind_e kd(input int i, w);
      return i < 5 ? (w ? K_WWORD : K_RWORD) : (w ? K_WBYTE : K_RBYTE);
   endfunction

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   initial begin
      int i, p;
      pads_in = 16'(rnd(65536));
      repeat (20) @(negedge clk);
      srst = 0;
      repeat (16) @(negedge clk);
      for (p = 0; p < 2; p++)
         for (i = 0; i < 8; i++) begin
            sh[p][i] = df[i];
            op(kd(i, 0), cd[i], 0, p[0], 0, df[i]);
         end
      for (int n = 0; n < 24; n++) begin
         i = rnd(8);
         p = rnd(2);
         v = i > 4 ? 16'(rnd(256)) : 16'(rnd(65536));
         op(kd(i, 1), cd[i], v, p[0], 0, 0);
         if (i == 6)
            v &= 16'h007f;
         sh[p][i] = v;
         if (i > 5)
            sh[1-p][i] = v;
         chk(cfg_words[i < 6 ? 2 * i + p : i + 6], v, "cfg");
         op(kd(i, 0), cd[i], 0, !p[0], 0, sh[1-p][i]);
         op(kd(i, 0), cd[i], 0, p[0], 0, v);
      end
      op(K_WWORD, 8'hd7, 16'h1234, 0, 1, 0);
      op(K_WBYTE, 8'hef, 16'h0012, 0, 1, 0);
      op(K_RWORD, 8'hd9, 0, 0, 1, 0);
      op(K_RBYTE, 8'hd6, 0, 0, 0, 16'h00c0);
      op(K_WWORD, 8'hf5, 16'h0001, 0, 1, 0);
      op(K_RBYTE, 8'hf5, 0, 0, 0, sh[0][7]);
      for (int n = 0; n < 40; n++) begin
         @(negedge clk);
         meas_valid = 1;
         meas_sel = 3'(rnd(8));
         meas_data = 16'(rnd(65536));
         if (meas_data > pk[meas_sel])
            pk[meas_sel] = meas_data;
      end
      @(negedge clk);
      meas_valid = 0;
      for (p = 0; p < 2; p++)
         for (i = 0; i < 5; i++)
            op(K_RWORD, pc[i], 0, p[0], 0, pk[slot(i, p)]);
      op(K_SEND, 8'he3, 0, 0, 0, 0);
      for (i = 0; i < 5; i++)
         op(K_RWORD, pc[i], 0, 1, 0, 0);
      for (int n = 0; n < 8; n++) begin
         @(negedge clk);
         flog_valid = 1;
         flog_data = 16'(rnd(65536));
         lg[n] = flog_data;
      end
      @(negedge clk);
      flog_valid = 0;
      op(K_SEND, 8'hea, 0, 0, 0, 0);
      op(K_SEND, 8'hec, 0, 0, 1, 0);
      repeat (12) @(negedge clk);
      op(K_RBYTE, 8'hef, 0, 0, 0, 16'h0004);
      op(K_BLOCK, 8'hee, 0, 0, 0, 16'h0010);
      repeat (20) @(negedge clk);
      chk(16'(host.blk_q.size()), 16'h0010, "block len");
      for (int n = 0; n < 16; n++)
         chk({8'h00, host.blk_q[n]}, n[0] ? lg[n/2][15:8] : lg[n/2][7:0], "byte");
      op(K_SEND, 8'hec, 0, 0, 0, 0);
      repeat (12) @(negedge clk);
      op(K_RBYTE, 8'hef, 0, 0, 0, 16'h0000);
      pulse(store_all_req);
      repeat (20) @(negedge clk);
      op(K_SEND, 8'hf0, 0, 0, 0, 0);
      op(K_SEND, 8'hf0, 0, 0, 1, 0);
      repeat (20) @(negedge clk);
      op(K_RBYTE, 8'hef, 0, 0, 0, 16'h0000);
      v = ~sh[0][0];
      op(K_WWORD, 8'hdb, v, 0, 0, 0);
      op(K_SEND, 8'hf0, 0, 0, 0, 0);
      repeat (20) @(negedge clk);
      op(K_RBYTE, 8'hef, 0, 0, 0, 16'h0002);
      pulse(restore_all_req);
      repeat (20) @(negedge clk);
      op(K_RWORD, 8'hdb, 0, 0, 0, sh[0][0]);
      op(K_WWORD, 8'hdb, v, 0, 0, 0);
      op(K_SEND, 8'hfd, 0, 0, 0, 0);
      chk({15'h0, soft_reset_pulse}, 16'h0001, "reset pulse");
      chk(cfg_words[0], df[0], "reset default");
      repeat (20) @(negedge clk);
      op(K_RWORD, 8'hdb, 0, 0, 0, sh[0][0]);
      op(K_RWORD, 8'he5, 0, 0, 0, pads_in);
      tally_and_finish();
   end
endmodule // test_pmbus_mfr_command_decoder
